/* rse_status_top.sv */
// Remote status, event and control logic of a programmable supply.
// Assumes a parser delivering decoded commands on the device clock.
`include "rse_defs.svh"

module rse_status_top #(
	parameter int unsigned TEST_CYCLES = `RSE_TEST_CYCLES,
	parameter int unsigned STEP_CYCLES = `RSE_STEP_CYCLES
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              nrst_i,
	// Decoded commands
	input  wire logic              cmd_valid_i,
	input  wire rse_pkg::rse_cmd_t cmd_i,
	output logic                   cmd_ready_o,
	input  wire logic              dcl_i,
	// Output buffer
	output rse_pkg::rse_resp_t     resp_o,
	input  wire logic              resp_rd_i,
	// Serial poll
	output logic [7:0]             stb_o,
	output logic                   srq_o,
	// Device function pins
	input  wire logic [7:0]        cond_i,
	input  wire logic [7:0]        erb_src_i,
	input  wire logic [7:0]        esr_src_i,
	input  wire logic              test_fail_i,
	input  wire logic              remote_i,
	input  wire logic              ocp_enable_i,
	// Control outputs
	output logic [4:0]             address_o,
	output logic                   unlisten_o,
	output logic                   panel_lock_o,
	output logic                   display_refresh_o,
	output logic                   output_off_o
);

	// ****************************************
	// Reset and input synchronisers
	// ****************************************
	logic [1:0]  rst_sync_q;
	logic        rst_n;
	logic [7:0]  cond_m_q, cond_s_q, erb_m_q, erb_s_q, esr_m_q, esr_s_q;

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cond_m_q <= 8'h00;
			cond_s_q <= 8'h00;
			erb_m_q  <= 8'h00;
			erb_s_q  <= 8'h00;
			esr_m_q  <= 8'h00;
			esr_s_q  <= 8'h00;
		end else begin
			cond_m_q <= cond_i;
			cond_s_q <= cond_m_q;
			erb_m_q  <= erb_src_i;
			erb_s_q  <= erb_m_q;
			esr_m_q  <= esr_src_i;
			esr_s_q  <= esr_m_q;
		end
	end

	// ****************************************
	// Event registers
	// ****************************************
	logic [7:0] live_condition_a;
	logic [7:0] era_val, erb_val, esr_val;
	logic       era_sum, erb_sum, esr_sum;
	logic [7:0] erb_src, esr_src;
	logic       fail_pulse_q, cme_pulse_q;
	logic       rd_era, rd_erb, rd_esr, cls;
	logic [7:0] erae_q, erbe_q, ese_q, sre_q;

	// Read-only view, no write path exists
	assign live_condition_a = cond_s_q;

	always_comb begin
		erb_src = erb_s_q;
		erb_src[`RSE_ERB_SELF_TEST_ERROR_BIT_BIT] = erb_s_q[`RSE_ERB_SELF_TEST_ERROR_BIT_BIT] | fail_pulse_q;
		esr_src = esr_s_q;
		esr_src[`RSE_ESR_CME_BIT] = esr_s_q[`RSE_ESR_CME_BIT] | cme_pulse_q;
	end

	rse_event_reg #(.W(8)) u_event_register_a (
		.clk_i    (ref_clk_i),
		.rst_n_i  (rst_n),
		.src_i    (live_condition_a),
		.rd_clr_i (rd_era),
		.clr_i    (cls),
		.ena_i    (erae_q),
		.val_o    (era_val),
		.sum_o    (era_sum)
	);

	rse_event_reg #(.W(8)) u_event_register_b (
		.clk_i    (ref_clk_i),
		.rst_n_i  (rst_n),
		.src_i    (erb_src),
		.rd_clr_i (rd_erb),
		.clr_i    (cls),
		.ena_i    (erbe_q),
		.val_o    (erb_val),
		.sum_o    (erb_sum)
	);

	rse_event_reg #(.W(8)) u_standard_event_register (
		.clk_i    (ref_clk_i),
		.rst_n_i  (rst_n),
		.src_i    (esr_src),
		.rd_clr_i (rd_esr),
		.clr_i    (cls),
		.ena_i    (ese_q),
		.val_o    (esr_val),
		.sum_o    (esr_sum)
	);

	// ****************************************
	// Command handling and self-test
	// ****************************************
	rse_pkg::rse_tst_state_t tst_q, tst_d;
	logic [31:0]        tcnt_q, tcnt_d;
	rse_pkg::rse_resp_t resp_q, resp_d;
	logic               mav_q, mav_d;
	logic [4:0]         addr_q, addr_d;
	logic [13:0]        delay_q, delay_d;
	logic               disp_q, disp_d, remote_q;
	logic [7:0]         erae_d, erbe_d, ese_d, sre_d;
	logic               fail_pulse_d, cme_pulse_d, test_done;
	logic               take;
	logic [7:0]         qval;

	function automatic logic [23:0] to_dec(input logic [7:0] v);
		logic [7:0] h, t, o;
		h = v / 8'h64;
		t = (v % 8'h64) / 8'h0A;
		o = v % 8'h0A;
		return {h + 8'h30, t + 8'h30, o + 8'h30};
	endfunction

	// Busy refuses data so a string never lands mid-test
	assign cmd_ready_o = (tst_q == rse_pkg::RSE_TST_IDLE);
	assign take        = cmd_valid_i && cmd_ready_o;
	assign test_done   = (tst_q == rse_pkg::RSE_TST_RUN) && (tcnt_q == 32'h0000_0000);
	assign rd_era      = take && (cmd_i.op == rse_pkg::RSE_OP_ERA_Q);
	assign rd_erb      = take && (cmd_i.op == rse_pkg::RSE_OP_ERB_Q);
	assign rd_esr      = take && (cmd_i.op == rse_pkg::RSE_OP_ESR_Q);
	assign cls         = take && (cmd_i.op == rse_pkg::RSE_OP_CLS);

	always_comb begin
		tst_d        = tst_q;
		tcnt_d       = tcnt_q;
		resp_d       = resp_q;
		mav_d        = mav_q;
		addr_d       = addr_q;
		delay_d      = delay_q;
		disp_d       = disp_q;
		erae_d       = erae_q;
		erbe_d       = erbe_q;
		ese_d        = ese_q;
		sre_d        = sre_q;
		fail_pulse_d = 1'b0;
		cme_pulse_d  = 1'b0;
		qval         = 8'h00;
		if (resp_rd_i) begin
			mav_d = 1'b0;
		end
		case (tst_q)
			rse_pkg::RSE_TST_RUN: begin
				tcnt_d = tcnt_q - 32'h0000_0001;
				if (test_done) begin
					tst_d        = rse_pkg::RSE_TST_IDLE;
					resp_d.len   = 2'h1;
					resp_d.chars = {16'h0000, test_fail_i ? 8'h31 : 8'h30};
					mav_d        = 1'b1;
					fail_pulse_d = test_fail_i;
				end
			end
			default: begin
				tst_d = rse_pkg::RSE_TST_IDLE;
			end
		endcase
		if (take) begin
			case (cmd_i.op)
				rse_pkg::RSE_OP_TST: begin
					tst_d  = rse_pkg::RSE_TST_RUN;
					tcnt_d = TEST_CYCLES - 32'h0000_0001;
				end
				rse_pkg::RSE_OP_ADDRESS: begin
					// Sub-address field is never looked at
					if (cmd_i.arg <= 14'(`RSE_ADDR_UNL)) begin
						addr_d = cmd_i.arg[4:0];
					end else begin
						cme_pulse_d = 1'b1;
					end
				end
				rse_pkg::RSE_OP_CRA_Q: qval = live_condition_a;
				rse_pkg::RSE_OP_ERA_Q: qval = era_val;
				rse_pkg::RSE_OP_ERB_Q: qval = erb_val;
				rse_pkg::RSE_OP_ESR_Q: qval = esr_val;
				rse_pkg::RSE_OP_ERAE:  erae_d = cmd_i.arg[7:0];
				rse_pkg::RSE_OP_ERBE:  erbe_d = cmd_i.arg[7:0];
				rse_pkg::RSE_OP_ESE:   ese_d = cmd_i.arg[7:0];
				rse_pkg::RSE_OP_SRE:   sre_d = cmd_i.arg[7:0];
				rse_pkg::RSE_OP_CLS: begin
				end
				rse_pkg::RSE_OP_DELAY: begin
					if (cmd_i.arg <= `RSE_DELAY_MAX) begin
						delay_d = cmd_i.arg;
					end else begin
						cme_pulse_d = 1'b1;
					end
				end
				rse_pkg::RSE_OP_DISPLAY: disp_d = cmd_i.arg[0];
				default: cme_pulse_d = 1'b1;
			endcase
			if (cmd_i.op inside {rse_pkg::RSE_OP_CRA_Q, rse_pkg::RSE_OP_ERA_Q,
					rse_pkg::RSE_OP_ERB_Q, rse_pkg::RSE_OP_ESR_Q}) begin
				resp_d.len   = 2'h3;
				resp_d.chars = to_dec(qval);
				mav_d        = 1'b1;
			end
		end
		if (remote_q && !remote_i) begin
			disp_d = 1'b1;
		end
		if (dcl_i) begin
			// Only buffers and the lockout go; registers are untouched
			tst_d  = rse_pkg::RSE_TST_IDLE;
			mav_d  = 1'b0;
			resp_d = '0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tst_q        <= rse_pkg::RSE_TST_IDLE;
			tcnt_q       <= 32'h0000_0000;
			resp_q       <= '0;
			mav_q        <= 1'b0;
			addr_q       <= `RSE_ADDR_RST;
			delay_q      <= `RSE_DELAY_RST;
			disp_q       <= 1'b1;
			remote_q     <= 1'b0;
			erae_q       <= `RSE_ENA_RST;
			erbe_q       <= `RSE_ENA_RST;
			ese_q        <= `RSE_ENA_RST;
			sre_q        <= `RSE_ENA_RST;
			fail_pulse_q <= 1'b0;
			cme_pulse_q  <= 1'b0;
		end else begin
			tst_q        <= tst_d;
			tcnt_q       <= tcnt_d;
			resp_q       <= resp_d;
			mav_q        <= mav_d;
			addr_q       <= addr_d;
			delay_q      <= delay_d;
			disp_q       <= disp_d;
			remote_q     <= remote_i;
			erae_q       <= erae_d;
			erbe_q       <= erbe_d;
			ese_q        <= ese_d;
			sre_q        <= sre_d;
			fail_pulse_q <= fail_pulse_d;
			cme_pulse_q  <= cme_pulse_d;
		end
	end

	// ****************************************
	// Overcurrent switch-off delay
	// ****************************************
	logic [31:0] step_q, step_d;
	logic [13:0] ocnt_q, ocnt_d;
	logic        off_q, off_d;
	logic        cc_s;

	assign cc_s = live_condition_a[`RSE_CRA_CC_BIT];

	always_comb begin
		step_d = step_q;
		ocnt_d = ocnt_q;
		off_d  = 1'b0;
		if (!cc_s || !ocp_enable_i) begin
			step_d = 32'h0000_0000;
			ocnt_d = 14'h0000;
		end else if (ocnt_q >= delay_q) begin
			off_d  = 1'b1;
		end else if (step_q == STEP_CYCLES - 32'h0000_0001) begin
			step_d = 32'h0000_0000;
			ocnt_d = ocnt_q + 14'h0001;
		end else begin
			step_d = step_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= 32'h0000_0000;
			ocnt_q <= 14'h0000;
			off_q  <= 1'b0;
		end else begin
			step_q <= step_d;
			ocnt_q <= ocnt_d;
			off_q  <= off_d;
		end
	end

	// ****************************************
	// Status byte and outputs
	// ****************************************
	// Poll is a pure read of flops, so it cannot touch the test
	always_comb begin
		stb_o = 8'h00;
		stb_o[`RSE_STB_ERB_BIT] = erb_sum;
		stb_o[`RSE_STB_ERA_BIT] = era_sum;
		stb_o[`RSE_STB_MAV_BIT] = mav_q;
		stb_o[`RSE_STB_ESR_BIT] = esr_sum;
		stb_o[`RSE_STB_MSS_BIT] = |(stb_o[5:2] & sre_q[5:2]);
	end

	assign srq_o             = stb_o[`RSE_STB_MSS_BIT];
	assign resp_o            = resp_q;
	assign address_o         = addr_q;
	assign unlisten_o        = (addr_q == `RSE_ADDR_UNL);
	assign panel_lock_o      = (tst_q == rse_pkg::RSE_TST_RUN);
	assign display_refresh_o = disp_q || !remote_i;
	assign output_off_o      = off_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	chk_busy_refuse: assert property ((panel_lock_o && cmd_valid_i) |=> $stable(addr_q) && $stable(sre_q))
		else $error("data accepted during self-test");
	chk_mav_on_done: assert property ((test_done && !dcl_i) |=> mav_q)
		else $error("MAV not set at self-test end");
	chk_self_test_error_bit_latch: assert property ((test_done && test_fail_i && !dcl_i)
		|-> ##2 erb_val[`RSE_ERB_SELF_TEST_ERROR_BIT_BIT])
		else $error("self-test error bit not latched");
	chk_srq_gating: assert property (srq_o |-> (erb_sum && sre_q[`RSE_STB_ERB_BIT])
		|| (era_sum && sre_q[3]) || (mav_q && sre_q[4]) || (esr_sum && sre_q[5]))
		else $error("service request without enabled source");
	chk_addr_range: assert property ((take && cmd_i.op == rse_pkg::RSE_OP_ADDRESS
		&& cmd_i.arg <= 14'(`RSE_ADDR_MAX)) |=> !unlisten_o)
		else $error("valid address read as unlisten");
	chk_dcl_keeps: assert property (dcl_i && !cmd_valid_i |=> !mav_q && $stable(sre_q)
		&& $stable(addr_q))
		else $error("device clear changed more than MAV");
	chk_ocp_cause: assert property (output_off_o |-> $past(cc_s) && $past(ocnt_q) >= $past(delay_q))
		else $error("output switched off without elapsed delay");
	chk_display_back: assert property ($fell(remote_i) |=> disp_q)
		else $error("display not restored on leaving remote");
	chk_cme_holds: assert property ((esr_val[`RSE_ESR_CME_BIT] && !rd_esr && !cls)
		|=> esr_val[`RSE_ESR_CME_BIT])
		else $error("command error bit lost before read");

	cov_test_pass: cover property (test_done && !test_fail_i);
	cov_test_fail: cover property (test_done && test_fail_i);
	cov_ocp_off:   cover property (output_off_o);
	cov_esr_read:  cover property (rd_esr && esr_val != 8'h00);

endmodule // rse_status_top

/* rse_defs.svh */
// Constants for the remote status and event logic.
// Assumes a single 100 MHz device clock.
`ifndef RSE_DEFS_SVH
`define RSE_DEFS_SVH

// ****************************************
// Field positions
// ****************************************
`define RSE_CRA_CC_BIT      1
`define RSE_ESR_CME_BIT     5
`define RSE_ERB_SELF_TEST_ERROR_BIT_BIT    2
`define RSE_STB_ERB_BIT     2
`define RSE_STB_ERA_BIT     3
`define RSE_STB_MAV_BIT     4
`define RSE_STB_ESR_BIT     5
`define RSE_STB_MSS_BIT     6

// ****************************************
// Reset values and ranges
// ****************************************
`define RSE_ADDR_RST        5'h00
`define RSE_ADDR_MAX        5'h1E
`define RSE_ADDR_UNL        5'h1F
`define RSE_DELAY_RST       14'h0000
`define RSE_DELAY_MAX       14'h270F
`define RSE_ENA_RST         8'h00

// ****************************************
// Timing
// ****************************************
`define RSE_CLK_HZ          100000000
`define RSE_TEST_TIME_S     6
`define RSE_STEP_TIME_MS    10
`define RSE_TEST_CYCLES     (`RSE_TEST_TIME_S * `RSE_CLK_HZ)
`define RSE_STEP_CYCLES     ((`RSE_STEP_TIME_MS * `RSE_CLK_HZ) / 1000)

`endif

/* rse_pkg.sv */
// Types shared by the remote status and event logic.
// Assumes the command parser upstream delivers decoded commands.
package rse_pkg;

	typedef enum logic [3:0] {
		RSE_OP_TST      = 4'h0,
		RSE_OP_ADDRESS  = 4'h1,
		RSE_OP_CRA_Q    = 4'h2,
		RSE_OP_ERA_Q    = 4'h3,
		RSE_OP_ERB_Q    = 4'h4,
		RSE_OP_ESR_Q    = 4'h5,
		RSE_OP_ERAE     = 4'h6,
		RSE_OP_ERBE     = 4'h7,
		RSE_OP_ESE      = 4'h8,
		RSE_OP_SRE      = 4'h9,
		RSE_OP_CLS      = 4'hA,
		RSE_OP_DELAY    = 4'hB,
		RSE_OP_DISPLAY  = 4'hC,
		RSE_OP_BAD      = 4'hF
	} rse_op_t;

	typedef struct packed {
		rse_op_t     op;
		logic [13:0] arg;
		logic [4:0]  sub_addr;
	} rse_cmd_t;

	typedef struct packed {
		logic [1:0]  len;
		logic [23:0] chars;
	} rse_resp_t;

	typedef enum logic [1:0] {
		RSE_TST_IDLE = 2'b01,
		RSE_TST_RUN  = 2'b10
	} rse_tst_state_t;

endpackage

/* rse_event_reg.sv */
// One edge-latched event register with its enable mask summary.
// Assumes sources are already in the device clock domain.
module rse_event_reg #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Event sources and clears
	input  wire logic [W-1:0] src_i,
	input  wire logic         rd_clr_i,
	input  wire logic         clr_i,
	input  wire logic [W-1:0] ena_i,
	// State
	output logic      [W-1:0] val_o,
	output logic              sum_o
);

	logic [W-1:0] val_q, val_d;
	logic [W-1:0] prev_q;
	logic [W-1:0] rise;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		rise  = src_i & ~prev_q;
		val_d = val_q;
		if (rd_clr_i || clr_i) begin
			val_d = '0;
		end
		// A rising edge in the clearing cycle survives
		val_d = val_d | rise;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			val_q  <= '0;
			prev_q <= '0;
		end else begin
			val_q  <= val_d;
			prev_q <= src_i;
		end
	end

	assign val_o = val_q;
	assign sum_o = |(val_q & ena_i);

	chk_edge_sets_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(rise != '0) |=> ((val_q & $past(rise)) == $past(rise)))
		else $error("rising source did not latch event bit");

endmodule // rse_event_reg

/* rse_host_model.sv */
// Host-side model of the decoded command port and the serial poll.
// Assumes the bench sequences calls to its tasks; requests are launched at rising edges.
module rse_host_model (
	// Clock
	input  wire logic         clk_i,
	// Status byte seen by polling, and the command ready flag
	input  wire logic [7:0]   stb_i,
	input  wire logic         cmd_ready_i,
	// Command side
	output rse_pkg::rse_cmd_t cmd_o,
	output logic              cmd_valid_o,
	output logic              dcl_o,
	output logic              resp_rd_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Idle levels
	// ****************************************
	initial begin
		cmd_o       = '0;
		cmd_valid_o = 1'b0;
		dcl_o       = 1'b0;
		resp_rd_o   = 1'b0;
	end

	// ****************************************
	// Requests
	// ****************************************
	// Returns one edge after the take, with the answer settled
	task automatic send(input rse_pkg::rse_op_t op, input logic [13:0] arg);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_o       <= '{op: op, arg: arg, sub_addr: 5'h15};
		// Request stands until an edge samples ready high
		do begin
			@(posedge clk_i);
		end while (!cmd_ready_i);
		cmd_valid_o <= 1'b0;
		// Released lines do not keep the last value
		cmd_o       <= ~cmd_o;
		@(posedge clk_i);
		#1;
	endtask

	// The test query always travels as a string of its own
	task automatic self_test();
		send(rse_pkg::RSE_OP_TST, 14'h0000);
	endtask

	// Polls MAV instead of reading the result early
	task automatic wait_mav(input int max_cycles, output logic ok);
		ok = 1'b0;
		for (int i = 0; i < max_cycles && !ok; i++) begin
			@(posedge clk_i);
			#1;
			ok = stb_i[4];
		end
	endtask

	task automatic take();
		@(posedge clk_i);
		resp_rd_o <= 1'b1;
		@(posedge clk_i);
		resp_rd_o <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	task automatic clear();
		@(posedge clk_i);
		dcl_o <= 1'b1;
		@(posedge clk_i);
		dcl_o <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
endmodule // rse_host_model

/* rse_status_top_tb.sv */
// Self-checking bench for the remote status and event logic.
// Assumes shortened self-test and delay-step counts; the host model drives commands.
module rse_status_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned TCYC = 20;
	localparam int unsigned SCYC = 4;

	// ****************************************
	// Signals
	// ****************************************
	logic              ref_clk;
	logic              nrst;
	logic              cmd_valid;
	rse_pkg::rse_cmd_t cmd;
	logic              cmd_ready;
	logic              dcl;
	rse_pkg::rse_resp_t resp;
	logic              resp_rd;
	logic [7:0]        stb;
	logic              srq;
	logic [7:0]        cond;
	logic [7:0]        erb_src;
	logic [7:0]        esr_src;
	logic              test_fail;
	logic              remote;
	logic              ocp_en;
	logic [4:0]        address;
	logic              unlisten;
	logic              panel_lock;
	logic              disp_ref;
	logic              out_off;
	int                fails;
	int                comparisons;
	logic              ok;

	initial begin
		ref_clk   = 1'b0;
		nrst      = 1'b0;
		cond      = 8'h00;
		erb_src   = 8'h00;
		esr_src   = 8'h00;
		test_fail = 1'b0;
		remote    = 1'b1;
		ocp_en    = 1'b0;
		fails       = 0;
		comparisons = 0;
	end

	always #5 ref_clk = ~ref_clk;

	// ****************************************
	// Instances
	// ****************************************
	rse_status_top #(.TEST_CYCLES(TCYC), .STEP_CYCLES(SCYC)) dut (
		.ref_clk_i(ref_clk), .nrst_i(nrst), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.cmd_ready_o(cmd_ready), .dcl_i(dcl), .resp_o(resp), .resp_rd_i(resp_rd),
		.stb_o(stb), .srq_o(srq), .cond_i(cond), .erb_src_i(erb_src),
		.esr_src_i(esr_src), .test_fail_i(test_fail), .remote_i(remote),
		.ocp_enable_i(ocp_en), .address_o(address), .unlisten_o(unlisten),
		.panel_lock_o(panel_lock), .display_refresh_o(disp_ref), .output_off_o(out_off)
	);

	rse_host_model host (
		.clk_i(ref_clk), .stb_i(stb), .cmd_ready_i(cmd_ready), .cmd_o(cmd),
		.cmd_valid_o(cmd_valid),
		.dcl_o(dcl), .resp_rd_o(resp_rd)
	);

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk(cmd_ready, 1'b1);
		chk(stb, 8'h00);
		chk(disp_ref, 1'b1);
	endtask

	// Bad command sticks through a valid one, then reads out and clears
	task automatic t_cme_addr();
		host.send(rse_pkg::RSE_OP_BAD, 14'h0000);
		host.send(rse_pkg::RSE_OP_ADDRESS, 14'h000D);
		chk(address, 5'h0D);
		chk(unlisten, 1'b0);
		host.send(rse_pkg::RSE_OP_ESR_Q, 14'h0000);
		chk(resp, 26'h3303332);
		chk(stb[4], 1'b1);
		host.send(rse_pkg::RSE_OP_ESR_Q, 14'h0000);
		chk(resp, 26'h3303030);
		host.send(rse_pkg::RSE_OP_ADDRESS, 14'h001E);
		chk(address, 5'h1E);
		host.send(rse_pkg::RSE_OP_ADDRESS, 14'h001F);
		chk(unlisten, 1'b1);
		host.take();
		chk(stb[4], 1'b0);
	endtask

	// Live condition stays put across reads; event A latches the edge once
	task automatic t_cond_events();
		host.send(rse_pkg::RSE_OP_CLS, 14'h0000);
		@(posedge ref_clk);
		cond    <= 8'h02;
		erb_src <= 8'h01;
		cycles(5);
		host.send(rse_pkg::RSE_OP_CRA_Q, 14'h0000);
		chk(resp, 26'h3303032);
		host.send(rse_pkg::RSE_OP_CRA_Q, 14'h0000);
		chk(resp, 26'h3303032);
		host.send(rse_pkg::RSE_OP_ERA_Q, 14'h0000);
		chk(resp, 26'h3303032);
		host.send(rse_pkg::RSE_OP_ERA_Q, 14'h0000);
		chk(resp, 26'h3303030);
		host.send(rse_pkg::RSE_OP_ERB_Q, 14'h0000);
		chk(resp, 26'h3303031);
		@(posedge ref_clk);
		cond    <= 8'h00;
		erb_src <= 8'h00;
		cycles(5);
		host.send(rse_pkg::RSE_OP_CRA_Q, 14'h0000);
		chk(resp, 26'h3303030);
		host.take();
	endtask

	// Failing self-test with both masks open raises a service request
	task automatic t_self_test();
		host.send(rse_pkg::RSE_OP_ERBE, 14'h0004);
		host.send(rse_pkg::RSE_OP_SRE, 14'h0004);
		@(posedge ref_clk);
		test_fail <= 1'b1;
		host.self_test();
		chk(cmd_ready, 1'b0);
		chk(panel_lock, 1'b1);
		// A command offered mid-test waits until the test ends
		fork
			host.send(rse_pkg::RSE_OP_ADDRESS, 14'h000A);
			begin
				cycles(6);
				chk(address, 5'h1F);
			end
		join
		chk(address, 5'h0A);
		host.wait_mav(TCYC + 10, ok);
		chk(ok, 1'b1);
		chk({resp.len, resp.chars[7:0]}, 10'h131);
		chk(stb[2], 1'b1);
		chk(srq, 1'b1);
		chk(cmd_ready, 1'b1);
		host.send(rse_pkg::RSE_OP_ERB_Q, 14'h0000);
		chk(resp, 26'h3303034);
		chk(srq, 1'b0);
		host.take();
		@(posedge ref_clk);
		test_fail <= 1'b0;
	endtask

	// Device clear drops MAV and a running test but keeps settings
	task automatic t_dcl();
		host.send(rse_pkg::RSE_OP_CRA_Q, 14'h0000);
		host.clear();
		chk(stb[4], 1'b0);
		chk(address, 5'h0A);
		host.self_test();
		chk(cmd_ready, 1'b0);
		host.clear();
		chk(cmd_ready, 1'b1);
		chk(panel_lock, 1'b0);
		cycles(TCYC + 5);
		chk(stb[4], 1'b0);
	endtask

	// Two SCYC-cycle delay steps of current regulation switch the output off
	task automatic t_ocp();
		host.send(rse_pkg::RSE_OP_DELAY, 14'h0002);
		@(posedge ref_clk);
		ocp_en <= 1'b1;
		cond   <= 8'h02;
		cycles(4);
		chk(out_off, 1'b0);
		cycles(2 * SCYC + 4);
		chk(out_off, 1'b1);
		@(posedge ref_clk);
		cond <= 8'h00;
		cycles(5);
		chk(out_off, 1'b0);
		@(posedge ref_clk);
		ocp_en <= 1'b0;
	endtask

	task automatic t_display();
		host.send(rse_pkg::RSE_OP_DISPLAY, 14'h0000);
		chk(disp_ref, 1'b0);
		@(posedge ref_clk);
		remote <= 1'b0;
		cycles(2);
		@(posedge ref_clk);
		remote <= 1'b1;
		cycles(2);
		chk(disp_ref, 1'b1);
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		cycles(4);
		t_reset();
		t_cme_addr();
		t_cond_events();
		t_self_test();
		t_dcl();
		t_ocp();
		t_display();
		end_sim();
	end

	// Whole run is a few hundred cycles; this leaves wide margin
	initial begin
		#50000;
		fails++;
		end_sim();
	end
endmodule // rse_status_top_tb
